// ===== core/sldrv_pkg.sv
// Purpose: Shared constants for the serial latched driver block.
// Assumes: One system clock; shift clock and strobe arrive as plain inputs.
// Notes:   Stage count is fixed by the device.
package sldrv_pkg;
	localparam int unsigned STAGES      = 10;
	localparam logic [9:0]  SHIFT_RESET = 10'h000;
	localparam logic [9:0]  LATCH_RESET = 10'h000;
endpackage : sldrv_pkg

// ===== core/sldrv_if.sv
// Purpose: Carries the shift register state from the shift stage to the top.
// Assumes: Same clock on both sides.
// Notes:   The shift module drives stages and the top reads them; the top drives shift_now.
`timescale 1ns/10ps
`default_nettype none
interface sldrv_if;
	import sldrv_pkg::*;
	logic [STAGES-1:0] stages;
	logic              shift_now;
	modport src (output stages, input shift_now);
	modport dst (input stages, output shift_now);
endinterface : sldrv_if
`default_nettype wire

// ===== core/sldrv_shift.sv
// Purpose: Ten-stage serial shift register advanced on shift clock edges.
// Assumes: shift_now is a one-cycle pulse marking a rising shift edge.
// Notes:   Stage 0 takes the serial input; the last stage feeds the chain.
`timescale 1ns/10ps
`default_nettype none
module sldrv_shift
	import sldrv_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic ce_i,
	// Serial data.
	input  wire logic serial_in_i,
	sldrv_if.src      sr
);
	typedef struct packed {
		logic [STAGES-1:0] sr;
	} sldrv_shift_s;

	sldrv_shift_s st;
	sldrv_shift_s next_st;

	always_comb begin
		next_st = st;
		if (sr.shift_now) begin
			next_st.sr = {st.sr[STAGES-2:0], serial_in_i}; // R1 R2 R3
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st.sr <= SHIFT_RESET;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign sr.stages = st.sr;

	a_shift_only_edge: assert property ( // R12
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && !sr.shift_now) |=> $stable(st.sr))
		else $error("Shift register changed without a shift edge.");
	a_shift_capture_in: assert property ( // R2
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && sr.shift_now) |=> st.sr[0] == $past(serial_in_i))
		else $error("First stage did not capture serial input.");
	a_shift_advance: assert property ( // R3
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && sr.shift_now) |=>
		st.sr[STAGES-1:1] == $past(st.sr[STAGES-2:0]))
		else $error("Shift register did not advance one stage.");
	a_shift_frozen: assert property ( // R12
		@(posedge clk_i) disable iff (!arst_n_i)
		!ce_i |=> $stable(st.sr))
		else $error("Shift register moved while the enable was low.");
endmodule : sldrv_shift
`default_nettype wire

// ===== core/sldrv_top.sv
// Purpose: Serial-input latched driver with ten blankable driver outputs.
// Assumes: Shift clock, strobe, blank and data are synchronous to clk_i.
// Notes:   Driver outputs lag strobe and blank by one clock cycle; a shift edge reaches the outputs two cycles later.
// Contract
// R1: Ten shift stages, one per driver output, loaded from the serial input.
// R2: A rising shift clock edge captures the serial input into stage one.
// R3: The same edge moves every bit one stage toward the serial output.
// R4: While the strobe is high the latch takes the shift register contents.
// R5: A strobe held high makes the latch transparent to the shift register.
// R6: While blanking is high every driver output is forced low.
// R7: Without strobe use the controller should blank while shifting.
// R8: The serial output always shows the last shift stage; the code registers it, so it follows that stage one clk_i cycle late.
// R9: Devices chain by wiring serial output to the next serial input.
// R10: With blanking low each driver output follows its latch bit.
// R11: With the strobe low the latch holds its contents.
// R12: The shift register changes only on rising shift clock edges.
`timescale 1ns/10ps
`default_nettype none
module sldrv_top
	import sldrv_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic              clk_i,
	input  wire logic              arst_n_i,
	input  wire logic              ce_i,
	// Controller pins.
	input  wire logic              shift_clk_i,
	input  wire logic              serial_in_i,
	input  wire logic              latch_strobe_i,
	input  wire logic              output_blank_i,
	// Chain and driver outputs.
	output logic                   serial_out_o,
	output logic [STAGES-1:0]      driver_output_o
);
	typedef struct packed {
		logic              clk_prev;
		logic [STAGES-1:0] latch;
		logic [STAGES-1:0] drv;
		logic              sout;
	} sldrv_top_s;

	sldrv_top_s st;
	sldrv_top_s next_st;
	sldrv_if    sr_if ();

	sldrv_shift u_shift (
		.clk_i       (clk_i),
		.arst_n_i    (arst_n_i),
		.ce_i        (ce_i),
		.serial_in_i (serial_in_i),
		.sr          (sr_if.src)
	);

	// Rising shift clock edge seen as a one-cycle pulse.
	assign sr_if.shift_now = shift_clk_i && !st.clk_prev; // R12

	always_comb begin
		next_st = st;
		next_st.clk_prev = shift_clk_i;
		if (latch_strobe_i) begin
			next_st.latch = sr_if.stages; // R4 R5
		end // R11: otherwise hold.
		if (output_blank_i) begin
			next_st.drv = '0; // R6
		end else begin
			next_st.drv = next_st.latch; // R10
		end
		next_st.sout = sr_if.stages[STAGES-1]; // R8 R9
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st.clk_prev <= 1'b0;
			st.latch    <= LATCH_RESET;
			st.drv      <= LATCH_RESET;
			st.sout     <= 1'b0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign serial_out_o    = st.sout;
	assign driver_output_o = st.drv;

	// Latch and driver behaviour, one cycle after the inputs are seen.

	a_blank_forces_low: assert property ( // R6
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && output_blank_i) |=> driver_output_o == '0)
		else $error("Outputs not low while blanked.");

	a_latch_holds: assert property ( // R11
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && !latch_strobe_i) |=> $stable(st.latch))
		else $error("Latch changed with strobe low.");

	a_latch_loads: assert property ( // R4
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && latch_strobe_i) |=> st.latch == $past(sr_if.stages))
		else $error("Latch did not take shift contents.");

	a_drive_follows: assert property ( // R10
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && !output_blank_i) |=> driver_output_o == st.latch)
		else $error("Outputs do not follow latch.");

	a_serial_out_last: assert property ( // R8
		@(posedge clk_i) disable iff (!arst_n_i)
		ce_i |=> serial_out_o == $past(sr_if.stages[STAGES-1]))
		else $error("Serial output is not the last stage.");

	a_transparent: assert property ( // R5
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && latch_strobe_i && !output_blank_i) |=>
		driver_output_o == $past(sr_if.stages))
		else $error("Transparent latch outputs wrong.");

	a_blank_over_strobe: assert property ( // R4 R6
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && output_blank_i && latch_strobe_i) |=>
		(driver_output_o == '0 && st.latch == $past(sr_if.stages)))
		else $error("Blanking did not win over a strobe load.");

	a_unblank_latch: assert property ( // R10 R11
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && !output_blank_i && !latch_strobe_i) |=>
		driver_output_o == $past(st.latch))
		else $error("Outputs do not show the held latch.");

	a_idle_stable: assert property ( // R11
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && !latch_strobe_i && !output_blank_i) ##1
		(ce_i && !latch_strobe_i && !output_blank_i) |=>
		$stable(driver_output_o))
		else $error("Outputs moved with strobe and blanking low.");

	a_drive_masked: assert property ( // R6 R10
		@(posedge clk_i) disable iff (!arst_n_i)
		ce_i |=> driver_output_o ==
		(st.latch & {STAGES{!$past(output_blank_i)}}))
		else $error("Outputs are neither the latch nor low.");

	// The latch takes the register as it stood before a same-cycle shift.
	a_load_pre_shift: assert property ( // R3 R4
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && latch_strobe_i && sr_if.shift_now) |=>
		st.latch[STAGES-2:0] == sr_if.stages[STAGES-1:1])
		else $error("Latch took the register after the shift.");

	a_transparent_chain: assert property ( // R2 R5
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && latch_strobe_i && !output_blank_i && sr_if.shift_now) ##1
		(ce_i && latch_strobe_i && !output_blank_i) |=>
		driver_output_o[0] == $past(serial_in_i, 2))
		else $error("First output does not show the new serial bit.");

	a_transparent_sout: assert property ( // R5 R8
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && latch_strobe_i && !output_blank_i) |=>
		driver_output_o[STAGES-1] == serial_out_o)
		else $error("Last output and serial output disagree.");

	// Serial output timing along the chain.

	a_sout_after_shift: assert property ( // R3 R8 R9
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && sr_if.shift_now) ##1 ce_i |=>
		serial_out_o == $past(sr_if.stages[STAGES-2], 2))
		else $error("Serial output did not take the next stage.");

	a_sout_quiet: assert property ( // R8 R12
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && !sr_if.shift_now) ##1 ce_i |=>
		$stable(serial_out_o))
		else $error("Serial output moved without a shift edge.");

	// Edge detection on the shift clock pin.

	a_edge_history: assert property ( // R12
		@(posedge clk_i) disable iff (!arst_n_i)
		ce_i |=> st.clk_prev == $past(shift_clk_i))
		else $error("Shift clock history lost a sample.");

	a_edge_single: assert property ( // R12
		@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && sr_if.shift_now) |=> !sr_if.shift_now)
		else $error("A held shift clock gave two shift edges.");

	// A low enable must leave every register as it was.

	a_freeze_latch: assert property ( // R11
		@(posedge clk_i) disable iff (!arst_n_i)
		!ce_i |=> $stable(st.latch))
		else $error("Latch moved while the enable was low.");

	a_freeze_drive: assert property ( // R10
		@(posedge clk_i) disable iff (!arst_n_i)
		!ce_i |=> $stable(driver_output_o))
		else $error("Outputs moved while the enable was low.");

	a_freeze_sout: assert property ( // R8
		@(posedge clk_i) disable iff (!arst_n_i)
		!ce_i |=> $stable(serial_out_o))
		else $error("Serial output moved while the enable was low.");

	a_freeze_edge: assert property ( // R12
		@(posedge clk_i) disable iff (!arst_n_i)
		!ce_i |=> $stable(st.clk_prev))
		else $error("Shift clock history moved while disabled.");

	// Each driver bit is checked on its own so a failure names the output.
	for (genvar g = 0; g < STAGES; g++) begin : g_bit
		a_bit_blank: assert property ( // R6
			@(posedge clk_i) disable iff (!arst_n_i)
			(ce_i && output_blank_i) |=> !driver_output_o[g])
			else $error("A blanked driver output is high.");

		a_bit_follow: assert property ( // R10
			@(posedge clk_i) disable iff (!arst_n_i)
			(ce_i && !output_blank_i) |=> driver_output_o[g] == st.latch[g])
			else $error("A driver output differs from its latch bit.");

		a_bit_load: assert property ( // R4
			@(posedge clk_i) disable iff (!arst_n_i)
			(ce_i && latch_strobe_i) |=>
			st.latch[g] == $past(sr_if.stages[g]))
			else $error("A latch bit did not take its stage.");

		a_bit_hold: assert property ( // R11
			@(posedge clk_i) disable iff (!arst_n_i)
			(ce_i && !latch_strobe_i) |=> $stable(st.latch[g]))
			else $error("A latch bit changed with strobe low.");
	end
endmodule : sldrv_top
`default_nettype wire

// ===== tb/sldrv_host.sv
// Purpose: Controller model driving the driver's pins.
// Assumes: Pins change just after a rising clk_i edge.
// Notes:   Each bit takes a low then a high shift clock cycle.
`timescale 1ns/10ps
`default_nettype none
module sldrv_host
	import sldrv_pkg::*;
(
	// Clock.
	input  wire logic clk_i,
	// Controller pins.
	output var logic  shift_clk_o,
	output var logic  serial_in_o,
	output var logic  latch_strobe_o,
	output var logic  output_blank_o
);
	initial begin
		{shift_clk_o, serial_in_o, latch_strobe_o, output_blank_o} = 4'h1;
	end
	task automatic shift_word(input logic [STAGES-1:0] w);
		for (int i = STAGES - 1; i >= 0; i--) begin
			@(posedge clk_i);
			shift_clk_o <= 1'b0;
			serial_in_o <= w[i];
			@(posedge clk_i);
			shift_clk_o <= 1'b1;
		end
		@(posedge clk_i);
		shift_clk_o <= 1'b0;
		serial_in_o <= ~w[0];
	endtask : shift_word
	task automatic pins(input logic strobe, input logic blank);
		@(posedge clk_i);
		latch_strobe_o <= strobe;
		output_blank_o <= blank;
	endtask : pins
endmodule : sldrv_host
`default_nettype wire

// ===== tb/tb_sldrv_top.sv
// Purpose: Self-checking bench for the serial latched driver.
// Assumes: Outputs settle within three cycles of the last input change.
// Notes:   Notes hold {serial_out, driver outputs}.
`timescale 1ns/10ps
`default_nettype none
module tb_sldrv_top;
	import sldrv_pkg::*;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic sclk, sin, stb, blk, sout, smp = 1'b0;
	logic ce = 1'b1;
	logic [STAGES-1:0] drv;
	logic [STAGES:0] exp_q[$];
	int errors = 0;
	int comparisons = 0;
	always #5 clk_i = ~clk_i;
	sldrv_host host_u (.clk_i(clk_i), .shift_clk_o(sclk), .serial_in_o(sin),
		.latch_strobe_o(stb), .output_blank_o(blk));
	sldrv_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce),
		.shift_clk_i(sclk), .serial_in_i(sin), .latch_strobe_i(stb),
		.output_blank_i(blk), .serial_out_o(sout), .driver_output_o(drv));
	task automatic check(input logic [STAGES:0] seen, input logic [STAGES:0] e);
		comparisons++;
		if (seen !== e) begin
			errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, e);
		end
	endtask : check
	task automatic note(input logic [STAGES:0] e);
		repeat (3) @(posedge clk_i);
		exp_q.push_back(e);
		smp <= 1'b1;
		@(posedge clk_i);
		smp <= 1'b0;
	endtask : note
	always @(posedge clk_i) begin
		if (smp && exp_q.size() > 0) begin
			check({sout, drv}, exp_q.pop_front());
		end
	end
	task automatic print_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict
	initial begin
		#100us;
		errors++;
		print_verdict();
	end
	initial begin
		logic [STAGES-1:0] a, b;
		void'($urandom(32'h0bfc469e));
		repeat (6) @(posedge clk_i);
		arst_n_i <= 1'b1;
		note('0);
		for (int k = 0; k < 3; k++) begin
			a = STAGES'($urandom());
			b = STAGES'($urandom());
			host_u.pins(1'b0, 1'b1);
			host_u.shift_word(a);
			host_u.pins(1'b1, 1'b1);
			host_u.pins(1'b0, 1'b0);
			note({a[STAGES-1], a});
			host_u.shift_word(b);
			note({b[STAGES-1], a});
			host_u.pins(1'b0, 1'b1);
			note({b[STAGES-1], {STAGES{1'b0}}});
			host_u.pins(1'b1, 1'b0);
			host_u.shift_word(a ^ b);
			note({a[STAGES-1] ^ b[STAGES-1], a ^ b});
			$display("test %0d done", k);
		end
		@(posedge clk_i);
		ce <= 1'b0;
		host_u.shift_word(b);
		host_u.pins(1'b0, 1'b1);
		note({a[STAGES-1] ^ b[STAGES-1], a ^ b});
		ce <= 1'b1;
		$display("test freeze done");
		print_verdict();
	end
endmodule : tb_sldrv_top
`default_nettype wire
